// ===== core/fesr_pkg.sv
/*
 Package for the extended status and drive control register of a serial flash:
 bit positions, reset values, command codes, default dummy counts and result kinds.
 Assumes a serial command decoder and an array engine that report to the register.
*/
package fesr_pkg;

   // Bit positions of the extended register
   localparam int EXT_BUSY_BIT = 0;
   localparam int EXT_PROT_BIT = 1;
   localparam int EXT_PERR_BIT = 2;
   localparam int EXT_EERR_BIT = 3;
   localparam int EXT_RSVD_BIT = 4;
   localparam int EXT_DRV_LSB = 5;
   localparam int EXT_DRV_MSB = 7;
   localparam int EXT_STATUS_MSB = 3;

   // Reset values
   localparam logic [7:0] EXT_RESET = 8'hf0;
   localparam logic [2:0] DRV_DEFAULT = 3'h7;
   localparam logic RSVD_VALUE = 1'b1;

   // Register write commands
   localparam logic [7:0] CMD_SET_EXT_NV = 8'h85;
   localparam logic [7:0] CMD_SET_EXT_V = 8'h83;

   // Fast read commands, normal and double rate forms
   localparam logic [7:0] CMD_FAST_A = 8'h0b;
   localparam logic [7:0] CMD_FAST_B = 8'h0c;
   localparam logic [7:0] CMD_FAST_DDR_A = 8'h0d;
   localparam logic [7:0] CMD_FAST_DDR_B = 8'h0e;
   localparam logic [7:0] CMD_DUAL_OUT_A = 8'h3b;
   localparam logic [7:0] CMD_DUAL_OUT_B = 8'h3c;
   localparam logic [7:0] CMD_DUAL_IO_A = 8'hbb;
   localparam logic [7:0] CMD_DUAL_IO_B = 8'hbc;
   localparam logic [7:0] CMD_DUAL_DDR_A = 8'hbd;
   localparam logic [7:0] CMD_DUAL_DDR_B = 8'hbe;
   localparam logic [7:0] CMD_QUAD_OUT_A = 8'h6b;
   localparam logic [7:0] CMD_QUAD_OUT_B = 8'h6c;
   localparam logic [7:0] CMD_QUAD_IO_A = 8'heb;
   localparam logic [7:0] CMD_QUAD_IO_B = 8'hec;
   localparam logic [7:0] CMD_QUAD_DDR_A = 8'hed;
   localparam logic [7:0] CMD_QUAD_DDR_B = 8'hee;

   // Default dummy cycle counts
   localparam logic [3:0] DUMMY_WIDE = 4'h8;
   localparam logic [3:0] DUMMY_QUAD = 4'h6;
   localparam logic [3:0] DUMMY_DUAL_IO = 4'h4;
   localparam logic [3:0] DUMMY_NONE = 4'h0;

   // Kinds of finished array or register operations
   typedef enum logic [3:0] {
      RES_PROGRAM,
      RES_INFO_PROG,
      RES_ASP_PROG,
      RES_UNLOCK,
      RES_STATUS_WRITE,
      RES_NV_REG_WRITE,
      RES_REG_PROG,
      RES_ERASE,
      RES_CHIP_ERASE
   } fesr_res_t;

   // Default dummy count per read command
   function automatic logic [3:0] dummy_default(input logic [7:0] op, input logic qpi);
      case (op)
         CMD_FAST_A, CMD_FAST_B, CMD_FAST_DDR_A, CMD_FAST_DDR_B:
            return qpi ? DUMMY_QUAD : DUMMY_WIDE;
         CMD_DUAL_OUT_A, CMD_DUAL_OUT_B, CMD_QUAD_OUT_A, CMD_QUAD_OUT_B:
            return DUMMY_WIDE;
         CMD_DUAL_IO_A, CMD_DUAL_IO_B, CMD_DUAL_DDR_A, CMD_DUAL_DDR_B:
            return DUMMY_DUAL_IO;
         CMD_QUAD_IO_A, CMD_QUAD_IO_B, CMD_QUAD_DDR_A, CMD_QUAD_DDR_B:
            return DUMMY_QUAD;
         default:
            return DUMMY_NONE;
      endcase
   endfunction

   // Drive strength in eighths of full drive, zero for reserved codes
   function automatic logic [3:0] drive_eighths(input logic [2:0] code);
      case (code)
         3'h1: return 4'h1;
         3'h2: return 4'h2;
         3'h3: return 4'h3;
         3'h5: return 4'h6;
         3'h6: return 4'h8;
         3'h7: return 4'h4;
         default: return 4'h0;
      endcase
   endfunction

endpackage

// ===== core/fesr_ext_reg.sv
/*
 Extended status and drive control register with its command and result handling.
 Assumes a serial command decoder on the link clock and an array engine on clk_sys
 that reports busy as a level and each finished operation as a one-cycle result.
*/
// Operation
// - Default dummy counts: 8, QPI/quad-IO 6, dual-IO 4
// - Double-rate dual IO read refused in QPI
// - Bits 7..5 select output drive strength
// - Bits 3..0 read-only, untouched by set commands
// - 85h writes non-volatile copy, 83h volatile
// - Bit 0 mirrors the busy bit
// - Protected target sets protection error flag
// - Program or NV write failure sets program error
// - Erase or NV update failure sets erase error
// - Protected or suspended program sets program+protection
// - Locked info row program sets program+protection
// - Bad mode lock program sets program+protection
// - Wrong unlock password sets program+protection
// - NV update erase/program failure sets matching flag
// - Locked status write sets protection+erase error
// - Protected erase sets erase+protection error
// - Chip erase flags only block protect bits
// - Flags stick until clear command or reset
// - Commands run normally while flags are set
// - Nonzero dummy field overrides default counts
`timescale 1ns/1ns
`default_nettype none

module fesr_ext_reg #(
   parameter logic [7:0] CMD_CLEAR = 8'h82,
   parameter logic [7:0] CMD_ID_READ = 8'h4b,
   parameter logic [7:0] CMD_ROW_READ = 8'h68
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic lnkClk,
   input wire logic lnkCmdValid,
   input wire logic [7:0] lnkCmdOp,
   input wire logic [7:0] lnkCmdArg,
   input wire logic lnkQpiMode,
   input wire logic [3:0] lnkDummyField,
   output logic lnkCmdAccept,
   output logic [3:0] lnkDummyCycles,
   output logic [7:0] lnkExtValue,
   input wire logic busyIn,
   input wire logic softReset,
   input wire logic resValid,
   input wire fesr_pkg::fesr_res_t resKind,
   input wire logic resFailProg,
   input wire logic resFailErase,
   input wire logic resProtected,
   input wire logic resSuspended,
   input wire logic resLocked,
   input wire logic resBpProt,
   input wire logic resModeLockChg,
   input wire logic resModeLock00,
   input wire logic resPwdMismatch,
   input wire logic resStatusWriteLock,
   output logic [7:0] extValue,
   output logic [2:0] driveCode,
   output logic [3:0] driveEighths,
   output logic driveReserved
);

   // The clear command code must not collide with the register write commands
   if (CMD_CLEAR == fesr_pkg::CMD_SET_EXT_NV || CMD_CLEAR == fesr_pkg::CMD_SET_EXT_V) begin : g_bad
      $error("clear command code collides with a set command");
   end

   // ---------------- Link domain ----------------
   logic lnkRstS1_reg, lnkRst_reg;
   logic cmdTog_reg;
   logic [7:0] cmdOpHold_reg, cmdArgHold_reg;
   logic [3:0] lnkDummy_reg;
   logic [7:0] lnkExt_reg;
   logic pubS1_reg, pubS2_reg, pubS3_reg;
   logic ackTog_reg;
   logic pubTog_reg;
   logic [7:0] pubData_reg;
   wire isDualDdr;
   wire isIdRead;
   wire isRegCmd;
   wire [3:0] defaultDummy;
   wire [3:0] dummyNext;
   wire pubEdge;

   // Reset brought into the link clock
   always_ff @(posedge lnkClk) begin
      lnkRstS1_reg <= rst;
      lnkRst_reg <= lnkRstS1_reg;
   end

   // Command screening and dummy count selection
   assign isDualDdr = (lnkCmdOp == fesr_pkg::CMD_DUAL_DDR_A) ||
                      (lnkCmdOp == fesr_pkg::CMD_DUAL_DDR_B);
   assign lnkCmdAccept = ~(lnkQpiMode & isDualDdr);
   assign isIdRead = (lnkCmdOp == CMD_ID_READ) || (lnkCmdOp == CMD_ROW_READ);
   assign defaultDummy = isIdRead ? (lnkQpiMode ? fesr_pkg::DUMMY_QUAD : fesr_pkg::DUMMY_WIDE)
                                  : fesr_pkg::dummy_default(lnkCmdOp, lnkQpiMode);
   assign dummyNext = (lnkDummyField != 4'h0) ? lnkDummyField : defaultDummy;
   assign isRegCmd = (lnkCmdOp == fesr_pkg::CMD_SET_EXT_NV) ||
                     (lnkCmdOp == fesr_pkg::CMD_SET_EXT_V) || (lnkCmdOp == CMD_CLEAR);

   // Dummy count latched per accepted command, register commands included
   always_ff @(posedge lnkClk) begin
      if (lnkRst_reg) begin
         lnkDummy_reg <= 4'h0;
      end else if (lnkCmdValid && lnkCmdAccept) begin
         lnkDummy_reg <= dummyNext;
      end
   end

   // Register commands held stable and announced by a toggle; the hold registers
   // are read from clk_sys, so commands must be spaced until the toggle has crossed
   always_ff @(posedge lnkClk) begin
      if (lnkRst_reg) begin
         cmdTog_reg <= 1'b0;
         cmdOpHold_reg <= 8'h00;
         cmdArgHold_reg <= 8'h00;
      end else if (lnkCmdValid && lnkCmdAccept && isRegCmd) begin
         cmdTog_reg <= ~cmdTog_reg;
         cmdOpHold_reg <= lnkCmdOp;
         cmdArgHold_reg <= lnkCmdArg;
      end
   end

   // Published register value taken into the link domain
   assign pubEdge = pubS2_reg ^ pubS3_reg;
   always_ff @(posedge lnkClk) begin
      if (lnkRst_reg) begin
         pubS1_reg <= 1'b0;
         pubS2_reg <= 1'b0;
         pubS3_reg <= 1'b0;
         ackTog_reg <= 1'b0;
         lnkExt_reg <= fesr_pkg::EXT_RESET;
      end else begin
         pubS1_reg <= pubTog_reg;
         pubS2_reg <= pubS1_reg;
         pubS3_reg <= pubS2_reg;
         ackTog_reg <= pubS2_reg;
         if (pubEdge) begin
            lnkExt_reg <= pubData_reg;
         end
      end
   end

   assign lnkDummyCycles = lnkDummy_reg;
   assign lnkExtValue = lnkExt_reg;

   // ---------------- System domain ----------------
   logic cmdS1_reg, cmdS2_reg, cmdS3_reg;
   logic ackS1_reg, ackS2_reg;
   logic [2:0] driveVol_reg, driveNv_reg;
   logic prot_reg, perr_reg, eerr_reg;
   logic busy_reg;
   wire cmdEvent;
   wire wrNv, wrVol, clrCmd, clrAll;
   wire isProg, isErase, isChip;
   wire setProt, setPerr, setEerr;
   wire protNext, perrNext, eerrNext;

   // Command toggle and acknowledge synchronisers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cmdS1_reg <= 1'b0;
         cmdS2_reg <= 1'b0;
         cmdS3_reg <= 1'b0;
         ackS1_reg <= 1'b0;
         ackS2_reg <= 1'b0;
      end else begin
         cmdS1_reg <= cmdTog_reg;
         cmdS2_reg <= cmdS1_reg;
         cmdS3_reg <= cmdS2_reg;
         ackS1_reg <= ackTog_reg;
         ackS2_reg <= ackS1_reg;
      end
   end

   // Command decode, independent of the error flags
   assign cmdEvent = cmdS2_reg ^ cmdS3_reg;
   assign wrNv = cmdEvent && (cmdOpHold_reg == fesr_pkg::CMD_SET_EXT_NV);
   assign wrVol = cmdEvent && ((cmdOpHold_reg == fesr_pkg::CMD_SET_EXT_V) || wrNv);
   assign clrCmd = cmdEvent && (cmdOpHold_reg == CMD_CLEAR);
   assign clrAll = clrCmd || softReset;

   // Drive strength copies; only bits 7..5 of the data byte are used
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         driveNv_reg <= fesr_pkg::DRV_DEFAULT;
         driveVol_reg <= fesr_pkg::DRV_DEFAULT;
      end else begin
         if (wrNv) begin
            driveNv_reg <= cmdArgHold_reg[fesr_pkg::EXT_DRV_MSB:fesr_pkg::EXT_DRV_LSB];
         end
         if (wrVol) begin
            driveVol_reg <= cmdArgHold_reg[fesr_pkg::EXT_DRV_MSB:fesr_pkg::EXT_DRV_LSB];
         end else if (softReset) begin
            driveVol_reg <= driveNv_reg;
         end
      end
   end

   // Classification of finished operations into error flags
   assign isProg = (resKind == fesr_pkg::RES_PROGRAM);
   assign isErase = (resKind == fesr_pkg::RES_ERASE);
   assign isChip = (resKind == fesr_pkg::RES_CHIP_ERASE);
   assign setProt = resValid && (
      (isProg && (resProtected || resSuspended)) ||
      (resKind == fesr_pkg::RES_INFO_PROG && resLocked) ||
      (resKind == fesr_pkg::RES_ASP_PROG && (resModeLockChg || resModeLock00)) ||
      (resKind == fesr_pkg::RES_UNLOCK && resPwdMismatch) ||
      (resKind == fesr_pkg::RES_STATUS_WRITE && resStatusWriteLock) ||
      (isErase && (resProtected || resLocked)) ||
      (isChip && resBpProt));
   assign setPerr = resValid && (
      (isProg && (resFailProg || resProtected || resSuspended)) ||
      (resKind == fesr_pkg::RES_INFO_PROG && (resFailProg || resLocked)) ||
      (resKind == fesr_pkg::RES_ASP_PROG &&
       (resFailProg || resModeLockChg || resModeLock00)) ||
      (resKind == fesr_pkg::RES_UNLOCK && resPwdMismatch) ||
      ((resKind == fesr_pkg::RES_STATUS_WRITE || resKind == fesr_pkg::RES_NV_REG_WRITE ||
        resKind == fesr_pkg::RES_REG_PROG) && resFailProg));
   assign setEerr = resValid && (
      ((isErase || isChip) && resFailErase) ||
      ((resKind == fesr_pkg::RES_STATUS_WRITE || resKind == fesr_pkg::RES_NV_REG_WRITE) &&
       resFailErase) ||
      (resKind == fesr_pkg::RES_STATUS_WRITE && resStatusWriteLock) ||
      (isErase && (resProtected || resLocked)) ||
      (isChip && resBpProt));

   // Sticky flags: a set in the clearing cycle wins
   assign protNext = (prot_reg & ~clrAll) | setProt;
   assign perrNext = (perr_reg & ~clrAll) | setPerr;
   assign eerrNext = (eerr_reg & ~clrAll) | setEerr;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prot_reg <= 1'b0;
         perr_reg <= 1'b0;
         eerr_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         prot_reg <= protNext;
         perr_reg <= perrNext;
         eerr_reg <= eerrNext;
         busy_reg <= busyIn;
      end
   end

   // Register image and drive outputs
   assign extValue = {driveVol_reg, fesr_pkg::RSVD_VALUE, eerr_reg, perr_reg, prot_reg,
                      busy_reg};
   assign driveCode = driveVol_reg;
   assign driveEighths = fesr_pkg::drive_eighths(driveVol_reg);
   assign driveReserved = (driveEighths == 4'h0);

   // Publish the register image to the link, one word per handshake
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pubTog_reg <= 1'b0;
         pubData_reg <= fesr_pkg::EXT_RESET;
      end else if ((ackS2_reg == pubTog_reg) && (pubData_reg != extValue)) begin
         pubTog_reg <= ~pubTog_reg;
         pubData_reg <= extValue;
      end
   end

   // ---------------- Checks ----------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_prot_program;
      resValid && isProg && (resProtected || resSuspended);
   endsequence
   sequence s_both_set;
      extValue[fesr_pkg::EXT_PROT_BIT] && extValue[fesr_pkg::EXT_PERR_BIT];
   endsequence

   // Result classification checks
   a_prot_program: assert property (s_prot_program |=> s_both_set)
      else $error("protected program did not set both flags");
   a_unlock_fail: assert property (
      resValid && resKind == fesr_pkg::RES_UNLOCK && resPwdMismatch |=> perr_reg && prot_reg)
      else $error("password mismatch did not set flags");
   a_status_locked: assert property (
      resValid && resKind == fesr_pkg::RES_STATUS_WRITE && resStatusWriteLock
      |=> eerr_reg && prot_reg)
      else $error("locked status write did not set flags");
   a_chip_asp_only: assert property (
      resValid && isChip && !resBpProt && !resFailErase && !eerr_reg && !prot_reg
      |=> !eerr_reg && !prot_reg)
      else $error("chip erase flagged without block protection");

   // Sticky flags and their clearing
   a_flag_sticky: assert property (eerr_reg && !clrAll |=> eerr_reg [*1])
      else $error("erase error flag dropped without clear");
   a_perr_sticky: assert property (perr_reg && !clrAll |=> perr_reg)
      else $error("program error flag dropped without clear");
   a_prot_sticky: assert property (prot_reg && !clrAll |=> prot_reg)
      else $error("protection flag dropped without clear");
   a_clear_flags: assert property (
      clrCmd && !resValid |=> !prot_reg && !perr_reg && !eerr_reg)
      else $error("clear command left a flag set");
   a_soft_clear: assert property (
      softReset && !resValid |=> !prot_reg && !perr_reg && !eerr_reg)
      else $error("software reset left a flag set");

   // Register writes and the busy mirror
   a_status_ro: assert property (wrVol && !resValid && !clrAll |=>
      $stable(extValue[fesr_pkg::EXT_STATUS_MSB:fesr_pkg::EXT_PROT_BIT]))
      else $error("set command changed status bits");
   a_drive_write: assert property (
      wrVol |=> ##1 driveCode == $past(cmdArgHold_reg[7:5], 2))
      else $error("drive code not written");
   a_drive_nv: assert property (
      wrNv |=> driveNv_reg == $past(cmdArgHold_reg[7:5]))
      else $error("stored drive code not written");
   a_busy_mirror: assert property (
      ##1 extValue[fesr_pkg::EXT_BUSY_BIT] == $past(busyIn))
      else $error("busy mirror differs from busy");

   // Link-side checks
   a_qpi_reject: assert property (@(posedge lnkClk) disable iff (lnkRst_reg)
      lnkCmdValid && lnkQpiMode && isDualDdr |-> !lnkCmdAccept ##1 $stable(lnkDummyCycles))
      else $error("double rate dual io accepted in qpi");
   a_dummy_dual: assert property (@(posedge lnkClk) disable iff (lnkRst_reg)
      lnkCmdValid && !lnkQpiMode && lnkDummyField == 4'h0 && lnkCmdOp == 8'hbb
      |=> lnkDummyCycles == 4'h4)
      else $error("dual io default dummy count wrong");
   a_dummy_quad: assert property (@(posedge lnkClk) disable iff (lnkRst_reg)
      lnkCmdValid && lnkQpiMode && lnkDummyField == 4'h0 && lnkCmdOp == fesr_pkg::CMD_FAST_B
      |=> lnkDummyCycles == 4'h6)
      else $error("qpi fast read default dummy count wrong");
   a_dummy_id: assert property (@(posedge lnkClk) disable iff (lnkRst_reg)
      lnkCmdValid && lnkDummyField == 4'h0 && lnkCmdOp == CMD_ID_READ
      |=> lnkDummyCycles == ($past(lnkQpiMode) ? 4'h6 : 4'h8))
      else $error("id read default dummy count wrong");
   a_dummy_field: assert property (@(posedge lnkClk) disable iff (lnkRst_reg)
      lnkCmdValid && lnkCmdAccept && lnkDummyField != 4'h0
      |=> lnkDummyCycles == $past(lnkDummyField))
      else $error("dummy field not honoured");

endmodule

`default_nettype wire

// ===== verification/fesr_host_model.sv
/*
 Host side of the serial command link: issues decoded commands, mode and dummy field.
 Assumes the register block's link ports and a free-running lnkClk.
*/
`timescale 1ns/1ns
`default_nettype none
module fesr_host_model (
   input wire logic lnkClk,
   input wire logic lnkCmdAccept,
   output logic lnkCmdValid,
   output logic [7:0] lnkCmdOp,
   output logic [7:0] lnkCmdArg,
   output logic lnkQpiMode,
   output logic [3:0] lnkDummyField
);
   logic taken;
   // Idle link, default dummy counts
   initial begin
      lnkCmdValid = 1'b0;
      lnkCmdOp = 8'h00;
      lnkCmdArg = 8'h00;
      lnkQpiMode = 1'b0;
      lnkDummyField = 4'h0;
      taken = 1'b0;
   end
   // One command pulse; released lines show the inverse, never a stale value
   task automatic send(input logic [7:0] op, input logic [7:0] arg);
      @(posedge lnkClk);
      #1;
      lnkCmdValid = 1'b1;
      lnkCmdOp = op;
      lnkCmdArg = arg;
      @(posedge lnkClk);
      taken = lnkCmdAccept;
      #1;
      lnkCmdValid = 1'b0;
      lnkCmdOp = ~op;
      lnkCmdArg = ~arg;
   endtask
   // Mode and dummy field change only between commands
   task automatic mode(input logic qpi, input logic [3:0] field);
      @(posedge lnkClk);
      #1;
      lnkQpiMode = qpi;
      lnkDummyField = field;
   endtask
endmodule
`default_nettype wire

// ===== verification/testbench.sv
/*
 Self-checking bench for the extended status and drive register.
 Assumes fesr_pkg, fesr_ext_reg and fesr_host_model are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
   localparam logic [7:0] CLR = 8'h82;
   localparam logic [7:0] IDR = 8'h4b;
   localparam logic [7:0] ROWR = 8'h68;
   logic clk_sys, rst, lnkClk, busyIn, softReset, resValid;
   logic lnkCmdValid, lnkQpiMode, lnkCmdAccept, driveReserved;
   logic [7:0] lnkCmdOp, lnkCmdArg, lnkExtValue, extValue;
   logic [3:0] lnkDummyField, lnkDummyCycles, driveEighths;
   logic [2:0] driveCode;
   logic [9:0] attr;
   fesr_pkg::fesr_res_t resKind;
   logic [3:0] eighth [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h0, 4'h6, 4'h8, 4'h4};
   int fail_count = 0;
   int n_compared = 0;

   fesr_ext_reg #(.CMD_CLEAR(CLR), .CMD_ID_READ(IDR),
      .CMD_ROW_READ(ROWR)) fesr_ext_reg_inst (
      .clk_sys(clk_sys), .rst(rst), .lnkClk(lnkClk), .lnkCmdValid(lnkCmdValid),
      .lnkCmdOp(lnkCmdOp), .lnkCmdArg(lnkCmdArg), .lnkQpiMode(lnkQpiMode),
      .lnkDummyField(lnkDummyField), .lnkCmdAccept(lnkCmdAccept),
      .lnkDummyCycles(lnkDummyCycles), .lnkExtValue(lnkExtValue), .busyIn(busyIn),
      .softReset(softReset), .resValid(resValid), .resKind(resKind),
      .resFailProg(attr[9]), .resFailErase(attr[8]), .resProtected(attr[7]),
      .resSuspended(attr[6]), .resLocked(attr[5]), .resBpProt(attr[4]),
      .resModeLockChg(attr[3]), .resModeLock00(attr[2]), .resPwdMismatch(attr[1]),
      .resStatusWriteLock(attr[0]), .extValue(extValue), .driveCode(driveCode),
      .driveEighths(driveEighths), .driveReserved(driveReserved));

   fesr_host_model fesr_host_model_inst (
      .lnkClk(lnkClk), .lnkCmdAccept(lnkCmdAccept), .lnkCmdValid(lnkCmdValid),
      .lnkCmdOp(lnkCmdOp), .lnkCmdArg(lnkCmdArg), .lnkQpiMode(lnkQpiMode),
      .lnkDummyField(lnkDummyField));

   // Two unrelated clocks
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      lnkClk = 1'b0;
      #7;
      forever #40 lnkClk = ~lnkClk;
   end

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic sys(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic lnk(input int n);
      repeat (n) @(posedge lnkClk);
      #1;
   endtask
   // Clear command, then all three flags must read zero
   task automatic clr();
      fesr_host_model_inst.send(CLR, 8'h00);
      lnk(3);
      chk("cleared", {5'h0, extValue[3:1]}, 8'h00);
   endtask
   // One finished operation; expected {erase, program, protection} a cycle later
   task automatic res(input fesr_pkg::fesr_res_t k, input logic [9:0] a,
                      input logic [2:0] e, input logic doClr);
      sys(1);
      resValid = 1'b1;
      resKind = k;
      attr = a;
      sys(1);
      resValid = 1'b0;
      attr = ~a;
      chk("flags", {5'h0, extValue[3:1]}, {5'h0, e});
      if (doClr) begin
         clr();
      end
   endtask
   // Read command; dummy count latched at the accepting link edge
   task automatic rd(input logic [7:0] op, input logic q, input logic [3:0] f,
                     input logic [3:0] e);
      fesr_host_model_inst.mode(q, f);
      fesr_host_model_inst.send(op, 8'h00);
      chk("dummy", {4'h0, lnkDummyCycles}, {4'h0, e});
   endtask

   // Hang guard
   initial begin
      #100000;
      fail_count++;
      final_report();
   end

   // Main sequence; reset spans seventy system cycles and three link edges
   initial begin
      rst = 1'b1;
      busyIn = 1'b0;
      softReset = 1'b0;
      resValid = 1'b0;
      resKind = fesr_pkg::RES_PROGRAM;
      attr = 10'h000;
      sys(70);
      chk("ext", extValue, 8'hf0);
      chk("drive", {4'h0, driveEighths}, 8'h04);
      chk("readback", lnkExtValue, 8'hf0);
      rst = 1'b0;
      lnk(3);
      res(fesr_pkg::RES_PROGRAM, 10'h080, 3'b011, 1'b0);
      res(fesr_pkg::RES_PROGRAM, 10'h000, 3'b011, 1'b0);
      rd(8'h0b, 1'b0, 4'h0, 4'h8);
      rd(8'h0c, 1'b1, 4'h0, 4'h6);
      rd(8'h0d, 1'b0, 4'h0, 4'h8);
      rd(8'h0e, 1'b1, 4'h0, 4'h6);
      rd(8'h3b, 1'b0, 4'h0, 4'h8);
      rd(8'h6c, 1'b0, 4'h0, 4'h8);
      rd(8'hbb, 1'b0, 4'h0, 4'h4);
      rd(8'hbe, 1'b0, 4'h0, 4'h4);
      rd(8'heb, 1'b0, 4'h0, 4'h6);
      rd(8'hed, 1'b1, 4'h0, 4'h6);
      rd(8'hbd, 1'b1, 4'h0, 4'h6);
      chk("accept", {7'h0, fesr_host_model_inst.taken}, 8'h00);
      rd(8'hec, 1'b1, 4'h5, 4'h5);
      rd(8'h0b, 1'b0, 4'hf, 4'hf);
      rd(8'hbc, 1'b0, 4'h0, 4'h4);
      rd(IDR, 1'b0, 4'h0, 4'h8);
      rd(ROWR, 1'b1, 4'h0, 4'h6);
      clr();
      for (int c = 0; c < 8; c++) begin
         fesr_host_model_inst.send(8'h83, {c[2:0], 5'h0f});
         lnk(6);
         chk("code", {5'h0, driveCode}, {5'h0, c[2:0]});
         chk("eighths", {4'h0, driveEighths}, {4'h0, eighth[c]});
         chk("rsvd", {7'h0, driveReserved}, {7'h0, c == 0 || c == 4});
         chk("ext", extValue, {c[2:0], 5'h10});
         chk("readback", lnkExtValue, {c[2:0], 5'h10});
      end
      res(fesr_pkg::RES_PROGRAM, 10'h040, 3'b011, 1'b1);
      res(fesr_pkg::RES_PROGRAM, 10'h200, 3'b010, 1'b1);
      res(fesr_pkg::RES_INFO_PROG, 10'h020, 3'b011, 1'b1);
      res(fesr_pkg::RES_ASP_PROG, 10'h008, 3'b011, 1'b1);
      res(fesr_pkg::RES_ASP_PROG, 10'h004, 3'b011, 1'b1);
      res(fesr_pkg::RES_UNLOCK, 10'h002, 3'b011, 1'b1);
      res(fesr_pkg::RES_NV_REG_WRITE, 10'h100, 3'b100, 1'b1);
      res(fesr_pkg::RES_NV_REG_WRITE, 10'h200, 3'b010, 1'b1);
      res(fesr_pkg::RES_STATUS_WRITE, 10'h001, 3'b101, 1'b1);
      res(fesr_pkg::RES_ERASE, 10'h080, 3'b101, 1'b1);
      res(fesr_pkg::RES_REG_PROG, 10'h200, 3'b010, 1'b1);
      res(fesr_pkg::RES_CHIP_ERASE, 10'h010, 3'b101, 1'b1);
      res(fesr_pkg::RES_CHIP_ERASE, 10'h080, 3'b000, 1'b1);
      sys(1);
      busyIn = 1'b1;
      sys(2);
      chk("busy", extValue, 8'hf1);
      busyIn = 1'b0;
      res(fesr_pkg::RES_ERASE, 10'h100, 3'b100, 1'b0);
      chk("ready", extValue, 8'hf8);
      fesr_host_model_inst.send(8'h85, 8'hc0);
      lnk(6);
      fesr_host_model_inst.send(8'h83, 8'h7f);
      lnk(6);
      chk("code", {5'h0, driveCode}, 8'h03);
      sys(1);
      softReset = 1'b1;
      sys(1);
      softReset = 1'b0;
      sys(2);
      chk("ext", extValue, 8'hd0);
      final_report();
   end
endmodule
`default_nettype wire
